// File: rtl/dsps_pkg.sv
// shared constants and types for the debug and serial pin function select
package dsps_pkg;

  // serial controller one operating modes
  typedef enum logic [1:0]
  {
    SER_OFF = 2'b00,
    SER_UART = 2'b01,
    SER_SPI = 2'b10,
    SER_TWI = 2'b11
  } dsps_ser_mode_type;

  // trace port modes chosen in the processor core
  typedef enum logic [1:0]
  {
    TRC_NONE = 2'b00,
    TRC_ASYNC = 2'b01,
    TRC_SYNC4 = 2'b10,
    TRC_SYNC_OTHER = 2'b11
  } dsps_trace_type;

  // serial wire select sequence detector states
  typedef enum logic [1:0]
  {
    SEQ_HUNT = 2'b00,
    SEQ_ARMED = 2'b01,
    SEQ_COLLECT = 2'b10
  } dsps_seq_type;

  // one pad as seen by the pad ring: drive, enable and pulls
  typedef struct packed
  {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
  } dsps_pin_type;

  localparam int T2_REMAP_BIT = 5;
  localparam int T2_CH2_EN_BIT = 1;
  localparam int DBG_GPIO_BIT = 5;
  localparam int PCH_PC2_BIT = 1;
  localparam int PB2_FIELD_LSB = 8;
  localparam int PC2_FIELD_LSB = 8;
  localparam int PC3_FIELD_LSB = 12;
  localparam logic [3:0] CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hd;
  localparam logic [5:0] SEQ_ONES = 6'h32;
  localparam logic [15:0] SEQ_CODE = 16'he79e;
  localparam logic [4:0] SEQ_LEN = 5'h10;
  localparam logic SWD_RESET = 1'b0;
  // synchroniser lanes
  localparam int IDX_PB2 = 0;
  localparam int IDX_PC2 = 1;
  localparam int IDX_PC3 = 2;
  localparam int IDX_PC4 = 3;
  localparam int IDX_ALT = 4;
  localparam int IDX_NRST = 5;
  localparam int SYNC_W = 6;

  // four-bit pin configuration field at a given position
  function automatic logic [3:0] dsps_field(input logic [15:0] cfg,
                                            input int lsb);
    return cfg[lsb +: 4];
  endfunction

endpackage

// File: rtl/dsps_pin_select.sv
// pin function selection for port b pin two and the debug pins
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - spi master: port b pin two feeds the master receive data
// - spi slave: port b pin two feeds the slave receive data
// - two-wire clock needs timer two channel two output off
// - two-wire clock drives open drain when field selects alternate
// - uart mode: port b pin two feeds uart receive
// - timer output needs remap, channel enable and alternate field
// - timer capture uses port b pin two only when remapped
// - serial wire mode: debug clock pin is the serial wire clock
// - jtag mode: debug clock pin is test clock with pull-down
// - port c pin two gpio needs debug gpio bit, high bit clear
// - jtag mode: port c pin two drives test data out
// - serial wire async trace drives trace output with pull-up
// - four-wire sync trace drives trace data bit zero
// - port c pin three gpio when debug gpio bit or serial wire
// - jtag mode: port c pin three is test data in, pull-up
// - trace enabled plus alternate field drives trace clock
// - jtag mode after reset and external reset low; tms pull-up
// - select sequence enters serial wire mode; swdio with pull-up
// - port c pin four gpio only with debug gpio bit
module dsps_pin_select
  import dsps_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic debug_clock,
  input wire logic external_reset_low,
  input wire logic port_b_pin_two_in,
  input wire logic port_c_pin_two_in,
  input wire logic port_c_pin_three_in,
  input wire logic port_c_pin_four_in,
  input wire logic timer_two_alt_pin_in,
  input wire dsps_ser_mode_type serial1_mode_select,
  input wire logic serial1_spi_config,
  input wire logic [3:0] timer_two_output_enables,
  input wire logic [7:0] timer_two_remap_option,
  input wire logic [15:0] port_b_low_config,
  input wire logic [15:0] port_c_low_config,
  input wire logic [15:0] port_c_high_config,
  input wire logic [7:0] debug_pin_config,
  input wire logic trace_enable,
  input wire dsps_trace_type trace_mode,
  input wire logic serial1_twowire_clock_out,
  input wire logic timer_two_channel_two,
  input wire logic debug_test_data_out,
  input wire logic swo_data,
  input wire logic sync_trace_bit_zero,
  input wire logic sync_trace_clock,
  input wire logic swdio_out,
  input wire logic swdio_oe,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  output dsps_pin_type port_b_pin_two,
  output dsps_pin_type port_c_pin_two,
  output dsps_pin_type port_c_pin_three,
  output dsps_pin_type port_c_pin_four,
  output dsps_pin_type debug_clock_pin,
  output logic serial1_master_in,
  output logic serial1_slave_in,
  output logic serial1_twowire_clock,
  output logic serial1_uart_receive,
  output logic timer_two_capture,
  output logic debug_test_data_in,
  output logic debug_test_mode_select,
  output logic swdio_in,
  output logic [3:0] gpio_in,
  output logic serial_wire_mode
);

  typedef struct packed
  {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic found1;
    logic found2;
    logic found3;
    logic link_clear;
    logic live;
    logic swd;
    dsps_pin_type pb2;
    dsps_pin_type pc2;
    dsps_pin_type pc3;
    dsps_pin_type pc4;
    dsps_pin_type dclk;
    logic master_in;
    logic slave_in;
    logic twi_clk;
    logic uart_rx;
    logic t2_cap;
    logic tdi;
    logic tms;
    logic swdio;
    logic [3:0] gpio;
  } dsps_state_type;

  typedef struct packed
  {
    logic clr1;
    logic clr2;
    dsps_seq_type state;
    logic [5:0] ones;
    logic [4:0] bits;
    logic [15:0] shreg;
    logic found;
  } dsps_link_type;

  dsps_state_type state_reg;
  dsps_state_type state_next;
  dsps_link_type link_reg;
  dsps_link_type link_next;

  logic remap5;
  logic t2_on;
  logic [3:0] pb2_f;
  logic [3:0] pc2_f;
  logic [3:0] pc3_f;
  logic spi_m;
  logic spi_s;
  logic tw_sel;
  logic t2_sel;
  logic dbg_gpio;
  logic pc2_gpio;
  logic [15:0] shifted;

  // configuration decode, same clock domain so no synchronising
  assign remap5 = timer_two_remap_option[T2_REMAP_BIT];
  assign t2_on = remap5 & timer_two_output_enables[T2_CH2_EN_BIT];
  assign pb2_f = dsps_field(port_b_low_config, PB2_FIELD_LSB);
  assign pc2_f = dsps_field(port_c_low_config, PC2_FIELD_LSB);
  assign pc3_f = dsps_field(port_c_low_config, PC3_FIELD_LSB);
  assign spi_m = (serial1_mode_select == SER_SPI) & serial1_spi_config;
  assign spi_s = (serial1_mode_select == SER_SPI) & ~serial1_spi_config;
  // timer output blocks the two-wire clock
  assign tw_sel = (serial1_mode_select == SER_TWI) &
                  (pb2_f == CFG_ALT_OD) & ~t2_on;
  // timer output needs all three conditions
  assign t2_sel = t2_on & (pb2_f == CFG_ALT_OUT);
  assign dbg_gpio = debug_pin_config[DBG_GPIO_BIT];
  // gpio needs the enable bit and the high bit clear
  assign pc2_gpio = dbg_gpio & ~port_c_high_config[PCH_PC2_BIT];
  assign shifted = {port_c_pin_four_in, link_reg.shreg[15:1]};

  // link side: watch swdio on the debug clock for the select sequence
  always_comb
  begin
    link_next = link_reg;
    link_next.clr1 = state_reg.link_clear;
    link_next.clr2 = link_reg.clr1;
    // ones run, then the lsb-first select code
    unique case (link_reg.state)
      SEQ_HUNT:
      begin
        if (!port_c_pin_four_in)
          link_next.ones = 6'h00;
        else if (link_reg.ones == SEQ_ONES - 6'h01)
          link_next.state = SEQ_ARMED;
        else
          link_next.ones = link_reg.ones + 6'h01;
      end
      SEQ_ARMED:
      begin
        // a fresh sequence retires the previous match
        link_next.found = 1'b0;
        if (!port_c_pin_four_in)
        begin
          link_next.state = SEQ_COLLECT;
          link_next.bits = 5'h01;
          link_next.shreg = shifted;
        end
      end
      SEQ_COLLECT:
      begin
        link_next.shreg = shifted;
        link_next.bits = link_reg.bits + 5'h01;
        if (link_reg.bits == SEQ_LEN - 5'h01)
        begin
          link_next.found = (shifted == SEQ_CODE);
          link_next.state = SEQ_HUNT;
          link_next.ones = 6'h00;
        end
      end
      default:
      begin
        link_next.state = SEQ_HUNT;
      end
    endcase
    // clear arrives through two flops; the clock only ticks in frames
    if (link_reg.clr2)
    begin
      link_next.state = SEQ_HUNT;
      link_next.ones = 6'h00;
      link_next.bits = 5'h00;
      link_next.shreg = 16'h0000;
      link_next.found = 1'b0;
    end
  end

  // link register, reset only through the crossed clear level
  always_ff @(posedge debug_clock)
  begin
    link_reg <= link_next;
  end

  // main side: synchronise pins, hold the debug mode, select functions
  always_comb
  begin
    state_next = state_reg;
    state_next.sync1 = {external_reset_low, timer_two_alt_pin_in,
                        port_c_pin_four_in, port_c_pin_three_in,
                        port_c_pin_two_in, port_b_pin_two_in};
    state_next.sync2 = state_reg.sync1;
    state_next.found1 = link_reg.found;
    state_next.found2 = state_reg.found1;
    state_next.found3 = state_reg.found2;
    state_next.link_clear = ~state_reg.sync2[IDX_NRST];
    // pins hold their reset image for one edge after release
    state_next.live = 1'b1;
    // external reset low returns to jtag mode
    if (!state_reg.sync2[IDX_NRST])
      state_next.swd = SWD_RESET;
    else if (state_reg.found2 & ~state_reg.found3)
      state_next.swd = 1'b1;

    state_next.master_in = spi_m ? state_reg.sync2[IDX_PB2] : 1'b0;
    state_next.slave_in = spi_s ? state_reg.sync2[IDX_PB2] : 1'b0;
    state_next.uart_rx = (serial1_mode_select == SER_UART) ?
                         state_reg.sync2[IDX_PB2] : 1'b1;
    state_next.twi_clk = tw_sel ? state_reg.sync2[IDX_PB2] : 1'b1;
    // capture from this pin only when remapped
    state_next.t2_cap = remap5 ? state_reg.sync2[IDX_PB2] :
                        state_reg.sync2[IDX_ALT];

    // port b pin two drive
    state_next.pb2 = '0;
    if (tw_sel)
    begin
      // open drain: pull low only, never drive high
      state_next.pb2.out = 1'b0;
      state_next.pb2.oe = ~serial1_twowire_clock_out;
    end
    else if (t2_sel)
    begin
      state_next.pb2.out = timer_two_channel_two;
      state_next.pb2.oe = 1'b1;
    end
    else
    begin
      // only gpio may drive when nothing else is selected
      state_next.pb2.out = gpio_out[IDX_PB2];
      state_next.pb2.oe = gpio_oe[IDX_PB2];
    end

    // debug clock is input only; pull-down in jtag
    state_next.dclk = '0;
    state_next.dclk.pull_down = ~state_next.swd;

    // port c pin two: gpio, then tdo, then trace outputs
    state_next.pc2 = '0;
    if (pc2_gpio)
    begin
      state_next.pc2.out = gpio_out[IDX_PC2];
      state_next.pc2.oe = gpio_oe[IDX_PC2];
    end
    else if (!state_next.swd)
    begin
      state_next.pc2.out = debug_test_data_out;
      state_next.pc2.oe = 1'b1;
    end
    else if (trace_enable && trace_mode == TRC_ASYNC &&
             pc2_f == CFG_ALT_OUT)
    begin
      state_next.pc2.out = swo_data;
      state_next.pc2.oe = 1'b1;
      state_next.pc2.pull_up = 1'b1;
    end
    else if (trace_enable && trace_mode == TRC_SYNC4 &&
             pc2_f == CFG_ALT_OUT)
    begin
      state_next.pc2.out = sync_trace_bit_zero;
      state_next.pc2.oe = 1'b1;
    end

    // port c pin three: trace clock wins because it is chosen explicitly
    state_next.pc3 = '0;
    if (trace_enable && pc3_f == CFG_ALT_OUT)
    begin
      state_next.pc3.out = sync_trace_clock;
      state_next.pc3.oe = 1'b1;
    end
    else if (dbg_gpio || state_next.swd)
    begin
      state_next.pc3.out = gpio_out[IDX_PC3];
      state_next.pc3.oe = gpio_oe[IDX_PC3];
    end
    else
    begin
      state_next.pc3.pull_up = 1'b1;
    end
    state_next.tdi = state_reg.sync2[IDX_PC3];

    // port c pin four: gpio, serial wire data or mode select
    state_next.pc4 = '0;
    if (dbg_gpio)
    begin
      // gpio only with the debug gpio bit
      state_next.pc4.out = gpio_out[IDX_PC4];
      state_next.pc4.oe = gpio_oe[IDX_PC4];
    end
    else if (state_next.swd)
    begin
      state_next.pc4.out = swdio_out;
      state_next.pc4.oe = swdio_oe;
      state_next.pc4.pull_up = 1'b1;
    end
    else
    begin
      state_next.pc4.pull_up = 1'b1;
    end
    // tms idles high so a gpio pin cannot walk the tap
    state_next.tms = (!dbg_gpio && !state_next.swd) ?
                     state_reg.sync2[IDX_PC4] : 1'b1;
    state_next.swdio = state_reg.sync2[IDX_PC4];
    state_next.gpio = state_reg.sync2[3:0];
  end

  // main register with synchronous reset
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.sync1[IDX_NRST] <= 1'b1;
      state_reg.sync2[IDX_NRST] <= 1'b1;
      state_reg.link_clear <= 1'b1;
      state_reg.swd <= SWD_RESET;
    end
    else
      state_reg <= state_next;
  end

  assign port_b_pin_two = state_reg.pb2;
  assign port_c_pin_two = state_reg.pc2;
  assign port_c_pin_three = state_reg.pc3;
  assign port_c_pin_four = state_reg.pc4;
  assign debug_clock_pin = state_reg.dclk;
  assign serial1_master_in = state_reg.master_in;
  assign serial1_slave_in = state_reg.slave_in;
  assign serial1_twowire_clock = state_reg.twi_clk;
  assign serial1_uart_receive = state_reg.uart_rx;
  assign timer_two_capture = state_reg.t2_cap;
  assign debug_test_data_in = state_reg.tdi;
  assign debug_test_mode_select = state_reg.tms;
  assign swdio_in = state_reg.swdio;
  assign gpio_in = state_reg.gpio;
  assign serial_wire_mode = state_reg.swd;

  // checks on the main clock
  default clocking main_cb @(posedge clock);
  endclocking
  // checks wait until the first decoded pin image has been registered
  default disable iff (!rst_b || !state_reg.live);

  spi_master_route_a: assert property (
    $past(spi_m) |-> serial1_master_in == $past(port_b_pin_two_in, 3))
    else $error("spi master data not routed");
  spi_slave_route_a: assert property (
    $past(spi_s) |-> serial1_slave_in == $past(port_b_pin_two_in, 3))
    else $error("spi slave data not routed");
  twi_timer_block_a: assert property (
    $past(serial1_mode_select == SER_TWI && t2_on) |->
    serial1_twowire_clock)
    else $error("two-wire clock taken while timer drives");
  twi_open_drain_a: assert property (
    $past(tw_sel) |-> !port_b_pin_two.out &&
    port_b_pin_two.oe == !$past(serial1_twowire_clock_out))
    else $error("two-wire clock not open drain");
  uart_rx_route_a: assert property (
    $past(serial1_mode_select == SER_UART) |->
    serial1_uart_receive == $past(port_b_pin_two_in, 3))
    else $error("uart receive not routed");
  timer_out_route_a: assert property (
    $past(t2_sel) |-> port_b_pin_two.oe &&
    port_b_pin_two.out == $past(timer_two_channel_two))
    else $error("timer output not on pin");
  timer_capture_a: assert property (
    $past(!remap5) |-> timer_two_capture == $past(timer_two_alt_pin_in, 3))
    else $error("timer capture not from alternate pin");
  swd_clock_pin_a: assert property (
    serial_wire_mode |-> !debug_clock_pin.oe && !debug_clock_pin.pull_down)
    else $error("serial wire clock pin misconfigured");
  jtag_clock_pull_a: assert property (
    !serial_wire_mode |-> debug_clock_pin.pull_down)
    else $error("test clock pull-down missing");
  pc2_gpio_sel_a: assert property (
    $past(pc2_gpio) |-> port_c_pin_two.oe == $past(gpio_oe[IDX_PC2]))
    else $error("port c pin two gpio not selected");
  pc2_tdo_drive_a: assert property (
    $past(!pc2_gpio) && !serial_wire_mode |-> port_c_pin_two.oe &&
    port_c_pin_two.out == $past(debug_test_data_out))
    else $error("test data out not driven");
  swo_trace_out_a: assert property (
    $past(!pc2_gpio && trace_enable && trace_mode == TRC_ASYNC &&
    pc2_f == CFG_ALT_OUT) && serial_wire_mode |->
    port_c_pin_two.pull_up && port_c_pin_two.out == $past(swo_data))
    else $error("async trace not driven");
  trace_bit0_out_a: assert property (
    $past(!pc2_gpio && trace_enable && trace_mode == TRC_SYNC4 &&
    pc2_f == CFG_ALT_OUT) && serial_wire_mode |->
    port_c_pin_two.out == $past(sync_trace_bit_zero))
    else $error("trace bit zero not driven");
  pc3_gpio_sel_a: assert property (
    $past(!(trace_enable && pc3_f == CFG_ALT_OUT) && dbg_gpio) |->
    port_c_pin_three.oe == $past(gpio_oe[IDX_PC3]))
    else $error("port c pin three gpio not selected");
  pc3_tdi_pull_a: assert property (
    $past(!dbg_gpio && !trace_enable) && !serial_wire_mode |->
    port_c_pin_three.pull_up && !port_c_pin_three.oe)
    else $error("test data in not an input with pull-up");
  trace_clock_out_a: assert property (
    $past(trace_enable && pc3_f == CFG_ALT_OUT) |->
    port_c_pin_three.out == $past(sync_trace_clock))
    else $error("trace clock not driven");
  jtag_after_reset_a: assert property (
    !$past(external_reset_low, 3) |-> !serial_wire_mode)
    else $error("not in jtag mode under external reset");
  swdio_pull_a: assert property (
    serial_wire_mode && $past(!dbg_gpio) |->
    port_c_pin_four.pull_up && port_c_pin_four.oe == $past(swdio_oe))
    else $error("swdio not selected in serial wire mode");
  pc4_gpio_only_a: assert property (
    $past(!dbg_gpio) && !serial_wire_mode |->
    !port_c_pin_four.oe && port_c_pin_four.pull_up)
    else $error("mode select pin driven in jtag mode");
  pb2_single_drv_a: assert property (
    $past(!tw_sel && !t2_sel) |->
    port_b_pin_two.oe == $past(gpio_oe[IDX_PB2]))
    else $error("peripheral drives unselected pin");

  // the match flag only rises on the full select code
  swd_code_match_a: assert property (
    @(posedge debug_clock) disable iff (link_reg.clr2)
    $rose(link_reg.found) |-> link_reg.shreg == SEQ_CODE)
    else $error("serial wire select without full code");

endmodule

`default_nettype wire

// File: rtl/dsps_pin_select_unused.sv
// intentionally empty
`timescale 1ns/1ps

// File: testbench/dsps_probe.sv
// debugger probe model: clocks select frames onto the mode pin
`timescale 1ns/1ps
`default_nettype none
module dsps_probe
  import dsps_pkg::*;
(
  input wire logic go,
  input wire logic bad,
  output logic debug_clock,
  output logic line,
  output logic busy
);
  // clock stands still low between frames; a released line sits at pull-up
  initial
  begin
    debug_clock = 1'b0;
    line = 1'b1;
    busy = 1'b0;
  end

  // probe drives clock pin and select frame
  always @(posedge go)
  begin : frame
    logic [15:0] code;
    int i;
    code = bad ? ~SEQ_CODE : SEQ_CODE;
    busy = 1'b1;
    #3;
    // odd offset keeps the link edges away from the main clock edges
    // trailing ones close a frame the detector left half collected
    for (i = 0; i < 74; i++)
    begin
      if (i < 50)
        line = 1'b1;
      else if (i < 66)
        line = code[i - 50];
      else
        line = 1'b1;
      #80 debug_clock = 1'b1;
      #80 debug_clock = 1'b0;
    end
    line = 1'b1;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the debug and serial pin function select
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dsps_pkg::*;
;
  logic clock, rst_b, ext_low, pb2_pad, pc2_pad, pc3_pad, alt_pad, spi_cfg;
  dsps_ser_mode_type smode;
  logic [3:0] t2en, g_out, g_oe, g_in;
  logic [7:0] t2remap, dbgcfg;
  logic [15:0] pbl, pcl, pch;
  logic tr_en, tw_out, t2ch2, tdo, swo, tb0, tclk, sw_out, sw_oe;
  dsps_trace_type tr_mode;
  dsps_pin_type pb2, pc2, pc3, pc4, dclk;
  logic m_in, s_in, tw_in, u_rx, cap, tdi, tms, sw_in, swm;
  logic dbg_clk, pc4_line, go, bad, busy;
  logic pb2_w, pc2_w, pc3_w, pc4_w;
  int failures, cmp_count;

  // wire level: the device wins while it drives, else the outside party
  assign pb2_w = pb2.oe ? pb2.out : pb2_pad;
  assign pc2_w = pc2.oe ? pc2.out : pc2_pad;
  assign pc3_w = pc3.oe ? pc3.out : pc3_pad;
  assign pc4_w = pc4.oe ? pc4.out : pc4_line;

  dsps_pin_select dut (.clock(clock), .rst_b(rst_b), .debug_clock(dbg_clk),
    .external_reset_low(ext_low), .port_b_pin_two_in(pb2_w),
    .port_c_pin_two_in(pc2_w), .port_c_pin_three_in(pc3_w),
    .port_c_pin_four_in(pc4_w), .timer_two_alt_pin_in(alt_pad),
    .serial1_mode_select(smode), .serial1_spi_config(spi_cfg),
    .timer_two_output_enables(t2en), .timer_two_remap_option(t2remap),
    .port_b_low_config(pbl), .port_c_low_config(pcl),
    .port_c_high_config(pch), .debug_pin_config(dbgcfg),
    .trace_enable(tr_en), .trace_mode(tr_mode),
    .serial1_twowire_clock_out(tw_out), .timer_two_channel_two(t2ch2),
    .debug_test_data_out(tdo), .swo_data(swo), .sync_trace_bit_zero(tb0),
    .sync_trace_clock(tclk), .swdio_out(sw_out), .swdio_oe(sw_oe),
    .gpio_out(g_out), .gpio_oe(g_oe), .port_b_pin_two(pb2),
    .port_c_pin_two(pc2), .port_c_pin_three(pc3), .port_c_pin_four(pc4),
    .debug_clock_pin(dclk), .serial1_master_in(m_in),
    .serial1_slave_in(s_in), .serial1_twowire_clock(tw_in),
    .serial1_uart_receive(u_rx), .timer_two_capture(cap),
    .debug_test_data_in(tdi), .debug_test_mode_select(tms),
    .swdio_in(sw_in), .gpio_in(g_in), .serial_wire_mode(swm));

  dsps_probe probe (.go(go), .bad(bad), .debug_clock(dbg_clk),
    .line(pc4_line), .busy(busy));

  // main clock, 100 MHz
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // pad inputs take two synchroniser edges plus one registered stage to show
  task automatic settle();
    repeat (5) @(negedge clock);
  endtask

  // one select frame from the probe, bounded wait for its end
  task automatic frame(input logic wrong);
    int n;
    n = 0;
    bad = wrong;
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
    while (busy === 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 2000)
    begin
      failures++;
      $display("mismatch at %0t: probe frame hung", $time);
      give_verdict();
    end
    repeat (10) @(negedge clock);
  endtask

  // main sequence; reset stays low long enough for link edges to clear it
  initial
  begin
    {rst_b, pb2_pad, pc2_pad, pc3_pad, alt_pad, spi_cfg, tr_en} = '0;
    {tw_out, t2ch2, tdo, swo, tb0, tclk, sw_out, sw_oe, go, bad} = '0;
    {t2en, g_out, g_oe, t2remap, dbgcfg, pbl, pcl, pch} = '0;
    smode = SER_OFF;
    tr_mode = TRC_NONE;
    ext_low = 1'b1;
    failures = 0;
    cmp_count = 0;
    frame(1'b1);
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    tdo = 1'b1;
    settle();
    chk({3'b000, swm}, 4'h0);
    chk(pc4 & 4'h7, 4'h2);
    chk({3'b000, tms}, 4'h1);
    chk(pc3 & 4'h7, 4'h2);
    chk({3'b000, tdi}, 4'h0);
    chk(dclk & 4'h7, 4'h1);
    chk(pc2 & 4'hc, 4'hc);
    // serial controller receive routing per mode
    smode = SER_SPI;
    spi_cfg = 1'b1;
    pb2_pad = 1'b1;
    settle();
    chk({1'b0, m_in, s_in, u_rx}, 4'h5);
    spi_cfg = 1'b0;
    settle();
    chk({1'b0, m_in, s_in, u_rx}, 4'h3);
    smode = SER_UART;
    pb2_pad = 1'b0;
    settle();
    chk({1'b0, m_in, s_in, u_rx}, 4'h0);
    // two-wire clock as open drain, then blocked by the timer
    smode = SER_TWI;
    pbl = 16'h0d00;
    pb2_pad = 1'b1;
    settle();
    chk(pb2 & 4'h4, 4'h4);
    chk({3'b000, tw_in}, 4'h0);
    tw_out = 1'b1;
    settle();
    chk(pb2 & 4'h4, 4'h0);
    t2remap = 8'h20;
    t2en = 4'h2;
    tw_out = 1'b0;
    settle();
    chk(pb2 & 4'h4, 4'h0);
    // timer channel two output and capture
    pbl = 16'h0900;
    t2ch2 = 1'b1;
    settle();
    chk(pb2 & 4'hc, 4'hc);
    chk({3'b000, cap}, 4'h1);
    t2en = 4'h0;
    alt_pad = 1'b1;
    pb2_pad = 1'b0;
    settle();
    chk(pb2 & 4'h4, 4'h0);
    chk({3'b000, cap}, 4'h0);
    t2remap = 8'h00;
    settle();
    chk({3'b000, cap}, 4'h1);
    // debug pins handed to general-purpose use
    smode = SER_OFF;
    dbgcfg = 8'h20;
    g_out = 4'hf;
    g_oe = 4'he;
    tdo = 1'b0;
    settle();
    chk(pc2 & 4'hc, 4'hc);
    chk(pc3 & 4'hc, 4'hc);
    chk(pc4 & 4'hc, 4'hc);
    pch = 16'h0002;
    settle();
    chk(pc2 & 4'hc, 4'h4);
    dbgcfg = 8'h00;
    pch = 16'h0000;
    tr_en = 1'b1;
    pcl = 16'h9000;
    tclk = 1'b1;
    settle();
    chk(pc3 & 4'hc, 4'hc);
    pcl = 16'h0000;
    // a wrong code is ignored, the right one enters serial wire mode
    frame(1'b1);
    chk({3'b000, swm}, 4'h0);
    frame(1'b0);
    chk({3'b000, swm}, 4'h1);
    sw_oe = 1'b1;
    settle();
    chk(pc4 & 4'he, 4'h6);
    chk(pc3 & 4'hc, 4'hc);
    chk(dclk & 4'h4, 4'h0);
    tr_mode = TRC_ASYNC;
    pcl = 16'h0900;
    swo = 1'b1;
    settle();
    chk(pc2 & 4'he, 4'he);
    tr_mode = TRC_SYNC4;
    settle();
    chk(pc2 & 4'hc, 4'h4);
    // external reset drops the port back to test-access mode
    ext_low = 1'b0;
    repeat (6) @(negedge clock);
    chk({3'b000, swm}, 4'h0);
    ext_low = 1'b1;
    give_verdict();
  end
endmodule
`default_nettype wire
